// >>> core/tmr_pkg.sv
// constants, modes and carrier types of the 16-bit timer block
package tmr_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_CH = 4;
  localparam int CNT_W  = 16;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 6;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_OPT  = 6'h04;
  localparam logic [5:0] OFF_EDGE = 6'h08;
  localparam logic [5:0] OFF_CNT  = 6'h0c;
  localparam logic [5:0] OFF_CH0  = 6'h10;
  localparam int         OFF_STEP = 4;

  // ****************************************
  // fields and values
  // ****************************************
  localparam int CTRL_RUN_BIT  = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_MODE_MSB = 3;
  localparam int OPT_WRAP_BIT  = 0;
  localparam int OPT_SEL_LSB   = 1;
  localparam int OPT_SEL_MSB   = 4;
  localparam int EDGE_MSB      = 7;

  localparam logic [15:0] CNT_MAX  = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE  = 16'h0001;

  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  typedef enum logic [2:0] {
    TMR_MODE_PWM  = 3'h4,
    TMR_MODE_FREE = 3'h5
  } tmr_mode_e;

  typedef struct packed {
    logic [2:0] mode;
    logic       run;
  } tmr_ctrl_s;

  typedef struct packed {
    logic [3:0] cap_sel;
    logic       wrap_flag;
  } tmr_opt_s;

endpackage

// >>> core/tmr_edge_detect.sv
// capture pin synchroniser and configurable edge detector
`timescale 1ns/1ns
module tmr_edge_detect (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  input  wire logic       pin_in,
  input  wire logic [1:0] edge_cfg_in,
  output logic            edge_out
);

  logic sync1;
  logic sync2;
  logic prev;

  // ****************************************
  // two-stage synchroniser, then edge compare
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev  <= 1'b0;
    end else if (ce_in) begin
      sync1 <= pin_in;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      edge_out <= 1'b0;
    end else if (ce_in) begin
      unique case (edge_cfg_in)
        tmr_pkg::EDGE_NONE: edge_out <= 1'b0;
        tmr_pkg::EDGE_RISE: edge_out <= sync2 & ~prev;
        tmr_pkg::EDGE_FALL: edge_out <= ~sync2 & prev;
        tmr_pkg::EDGE_BOTH: edge_out <= sync2 ^ prev;
      endcase
    end
  end

endmodule

// >>> core/tmr_top.sv
// 16-bit timer: pwm and free-running modes with avalon-mm register slave
//
// Behaviour
// - pwm mode: run enable clears counter ffff to 0000, drives pwm outputs 1-3
// - pwm mode: compare output 0 toggles once per pwm period
// - period is channel-0 value plus one; output k active channel-k counts
// - pwm compare writes land in holding regs, loaded at period wrap
// - buffers load only at run start or after channel-1 write, all four together at clear
// - channel-0 irq on the step after match, together with clear to 0000
// - channel-k irq in the cycle the counter equals the channel-k value
// - value 0000 gives 0% duty; irq still fires once per period, at the clear to 0000
// - value equal to period gives 100% duty; impossible with channel-0 ffff
// - pwm mode ignores capture edge config and option settings
// - free mode: run enable starts counting; select bits pick capture/compare
// - free compare: enable inverts all outputs; each match toggles and irqs
// - free mode: step after ffff, except the first step after run enable, raises wrap irq, sets flag, wraps to 0000
// - wrap flag stays set until software clears it by writing zero
// - free compare values unbuffered, used from the moment written
// - free capture: valid edge copies count into channel, raises irq
// - flag clear colliding with new wrap leaves the flag set
`timescale 1ns/1ns
module tmr_top (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  input  wire logic        count_tick_in,
  input  wire logic [5:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic [3:0]  capture_in_m_in,
  output logic             compare_out_0_out,
  output logic [2:0]       pwm_out_k_out,
  output logic             period_match_irq_out,
  output logic [2:0]       chan_match_irq_out,
  output logic             wrap_irq_out,
  output logic             wrap_flag_out
);

  // ****************************************
  // state
  // ****************************************
  tmr_pkg::tmr_ctrl_s ctrl;
  tmr_pkg::tmr_opt_s  opt;
  logic [7:0]         edge_cfg;
  logic [15:0]        cnt;
  logic [15:0]        next_cnt;
  logic               run_prev;
  logic               first;
  logic               pend;
  logic               wrap_irq;
  logic               wait_q;
  logic [31:0]        rdata;
  logic [31:0]        next_rdata;
  logic [15:0]        chan_v [0:3];
  logic [15:0]        buf_v  [0:3];
  wire logic [3:0]    out_vec;
  wire logic [3:0]    irq_vec;

  wire logic       is_pwm   = (ctrl.mode == tmr_pkg::TMR_MODE_PWM);
  wire logic       is_free  = (ctrl.mode == tmr_pkg::TMR_MODE_FREE);
  wire logic       start    = ctrl.run & ~run_prev;
  wire logic       tick     = ce_in & count_tick_in & ctrl.run & (is_pwm | is_free);
  wire logic       pwm_wrap = is_pwm & ((cnt == buf_v[0]) | (cnt == tmr_pkg::CNT_MAX));
  wire logic       reload   = tick & pwm_wrap & (pend | first);
  wire logic       ovf      = tick & is_free & (cnt == tmr_pkg::CNT_MAX) & ~first;
  wire logic       req      = avs_read_in | avs_write_in;
  wire logic       wr_en    = ce_in & avs_write_in & ~wait_q;
  wire logic [5:0] waddr    = {avs_address_in[5:2], 2'h0};
  wire logic       be0      = avs_byteenable_in[0];
  wire logic       wr_ch1   = wr_en & (waddr == tmr_pkg::OFF_CH0 + 6'(tmr_pkg::OFF_STEP));

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    merge16 = old;
    if (be[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (be[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction

  // ****************************************
  // avalon-mm slave: one wait cycle per access
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wait_q <= 1'b1;
      rdata  <= 32'h0000_0000;
    end else if (ce_in) begin
      wait_q <= ~(req & wait_q);
      if (avs_read_in & wait_q) begin
        rdata <= next_rdata;
      end
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (waddr[5:4] == tmr_pkg::OFF_CH0[5:4]) begin
      next_rdata = {16'h0000, chan_v[waddr[3:2]]};
    end else begin
      unique case (waddr)
        tmr_pkg::OFF_CTRL: next_rdata = {28'h0000000, ctrl};
        tmr_pkg::OFF_OPT:  next_rdata = {27'h0000000, opt};
        tmr_pkg::OFF_EDGE: next_rdata = {24'h000000, edge_cfg};
        tmr_pkg::OFF_CNT:  next_rdata = {16'h0000, cnt};
        default:           next_rdata = 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata_out    = rdata;
  assign avs_waitrequest_out = wait_q;

  // ****************************************
  // control, option and edge registers
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl     <= '0;
      edge_cfg <= 8'h00;
      opt.cap_sel <= 4'h0;
    end else if (wr_en & be0) begin
      if (waddr == tmr_pkg::OFF_CTRL) begin
        ctrl.mode <= avs_writedata_in[tmr_pkg::CTRL_MODE_MSB:tmr_pkg::CTRL_MODE_LSB];
        ctrl.run  <= avs_writedata_in[tmr_pkg::CTRL_RUN_BIT];
      end
      if (waddr == tmr_pkg::OFF_OPT) begin
        opt.cap_sel <= avs_writedata_in[tmr_pkg::OPT_SEL_MSB:tmr_pkg::OPT_SEL_LSB];
      end
      if (waddr == tmr_pkg::OFF_EDGE) begin
        edge_cfg <= avs_writedata_in[tmr_pkg::EDGE_MSB:0];
      end
    end
  end

  // set wins over a colliding clear; writing one never sets the flag
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      opt.wrap_flag <= 1'b0;
    end else if (ovf) begin
      opt.wrap_flag <= 1'b1;
    end else if (wr_en & be0 & (waddr == tmr_pkg::OFF_OPT)
                 & ~avs_writedata_in[tmr_pkg::OPT_WRAP_BIT]) begin
      opt.wrap_flag <= 1'b0;
    end
  end

  // ****************************************
  // counter
  // ****************************************
  always_comb begin
    if (pwm_wrap) begin
      next_cnt = tmr_pkg::CNT_ZERO;
    end else begin
      next_cnt = cnt + tmr_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt <= tmr_pkg::CNT_MAX;
    end else if (ce_in) begin
      if (!ctrl.run) begin
        cnt <= tmr_pkg::CNT_MAX;
      end else if (tick) begin
        cnt <= next_cnt;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      run_prev <= 1'b0;
      first    <= 1'b1;
      wrap_irq <= 1'b0;
    end else if (ce_in) begin
      run_prev <= ctrl.run;
      wrap_irq <= ovf;
      if (!ctrl.run) begin
        first <= 1'b1;
      end else if (tick) begin
        first <= 1'b0;
      end
    end
  end

  // a channel-1 write during a transfer keeps the request; buffers then hold mixed data
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pend <= 1'b0;
    end else if (ce_in) begin
      if (wr_ch1 & is_pwm) begin
        pend <= 1'b1;
      end else if (reload) begin
        pend <= 1'b0;
      end
    end
  end

  // ****************************************
  // per-channel compare, capture and output
  // ****************************************
  genvar m;
  generate
    for (m = 0; m < tmr_pkg::NUM_CH; m++) begin : g_ch
      localparam logic [5:0] CH_ADDR = tmr_pkg::OFF_CH0 + 6'(tmr_pkg::OFF_STEP * m);
      logic [15:0] ch_reg;
      logic [15:0] ch_buf;
      logic [15:0] buf_eff;
      logic        out_r;
      logic        irq_r;
      logic        cap_pend;
      logic        cap_edge;
      logic        cap_en;
      logic        cap_hit;

      assign cap_en  = is_free & opt.cap_sel[m];
      assign cap_hit = cap_pend | cap_edge;
      assign buf_eff = reload ? ch_reg : ch_buf;

      tmr_edge_detect u_edge (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .ce_in       (ce_in),
        .pin_in      (capture_in_m_in[m]),
        .edge_cfg_in (cap_en ? edge_cfg[2*m+1:2*m] : tmr_pkg::EDGE_NONE),
        .edge_out    (cap_edge)
      );

      // an edge between ticks waits for the next tick
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          cap_pend <= 1'b0;
        end else if (ce_in) begin
          if (!cap_en | tick) begin
            cap_pend <= 1'b0;
          end else if (cap_edge) begin
            cap_pend <= 1'b1;
          end
        end
      end

      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          ch_reg <= tmr_pkg::CNT_ZERO;
        end else if (ce_in) begin
          if (tick & cap_en & cap_hit) begin
            ch_reg <= cnt;
          end else if (wr_en & (waddr == CH_ADDR)) begin
            ch_reg <= merge16(ch_reg, avs_writedata_in, avs_byteenable_in);
          end
        end
      end

      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          ch_buf <= tmr_pkg::CNT_ZERO;
        end else if (reload) begin
          ch_buf <= ch_reg;
        end
      end

      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          out_r <= 1'b0;
          irq_r <= 1'b0;
        end else if (ce_in) begin
          irq_r <= 1'b0;
          if (!ctrl.run) begin
            out_r <= 1'b0;
          end else if (start & is_free) begin
            out_r <= ~out_r;
          end else if (tick & is_pwm) begin
            if (m == 0) begin
              if (pwm_wrap & ~first) begin
                out_r <= ~out_r;
                irq_r <= 1'b1;
              end
            end else begin
              out_r <= (next_cnt < buf_eff);
              irq_r <= (next_cnt == buf_eff);
            end
          end else if (tick & cap_en) begin
            irq_r <= cap_hit;
          end else if (tick & (next_cnt == ch_reg)) begin
            out_r <= ~out_r;
            irq_r <= 1'b1;
          end
        end
      end

      assign chan_v[m]  = ch_reg;
      assign buf_v[m]   = ch_buf;
      assign out_vec[m] = out_r;
      assign irq_vec[m] = irq_r;
    end
  endgenerate

  assign compare_out_0_out    = out_vec[0];
  assign pwm_out_k_out        = out_vec[3:1];
  assign period_match_irq_out = irq_vec[0];
  assign chan_match_irq_out   = irq_vec[3:1];
  assign wrap_irq_out         = wrap_irq;
  assign wrap_flag_out        = opt.wrap_flag;

  // ****************************************
  // assertions
  // ****************************************
  a_stop_loads_max: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && !ctrl.run) |=> (cnt == tmr_pkg::CNT_MAX))
    else $error("counter not at max after stop");

  a_pwm_wrap_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (tick && is_pwm && cnt == buf_v[0]) |=> (cnt == tmr_pkg::CNT_ZERO))
    else $error("pwm counter did not clear at period match");

  a_period_irq_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (tick && is_pwm && cnt == buf_v[0] && !first)
      |=> (period_match_irq_out && cnt == tmr_pkg::CNT_ZERO))
    else $error("period irq not with counter clear");

  a_out0_toggle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (tick && is_pwm && cnt == buf_v[0] && !first)
      |=> (compare_out_0_out != $past(compare_out_0_out)))
    else $error("compare output 0 did not toggle at period");

  a_no_reload_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (tick && is_pwm && !pend && !first) |=> $stable(buf_v[1]))
    else $error("buffer changed without channel 1 write");

  a_zero_duty: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (tick && is_pwm && !reload && buf_v[1] == tmr_pkg::CNT_ZERO) |=> !pwm_out_k_out[0])
    else $error("zero value did not hold output inactive");

  a_chan_irq_match: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (tick && is_pwm && !reload && next_cnt == buf_v[2])
      |=> (chan_match_irq_out[1] && cnt == buf_v[2]))
    else $error("channel irq not aligned with count match");

  a_wrap_sets_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ovf |=> (wrap_flag_out && wrap_irq_out && cnt == tmr_pkg::CNT_ZERO))
    else $error("wrap did not raise irq and flag");

  a_flag_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wrap_flag_out && !(wr_en && waddr == tmr_pkg::OFF_OPT)) |=> wrap_flag_out)
    else $error("wrap flag cleared without software write");

  a_free_toggle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (tick && is_free && !start && !opt.cap_sel[1] && next_cnt == chan_v[1])
      |=> (pwm_out_k_out[0] != $past(pwm_out_k_out[0]) && chan_match_irq_out[0]))
    else $error("free compare match did not toggle output");

  a_bus_one_wait: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && req && wait_q) |=> !avs_waitrequest_out)
    else $error("waitrequest not released after one cycle");

endmodule

// >>> sim/tmr_ext_model.sv
// external load on compare output 0 and drivers of the capture pins
`timescale 1ns/1ns
module tmr_ext_model (
  input  wire logic       clk_in,
  input  wire logic [3:0] pin_level_in,
  input  wire logic       compare_out_0_in,
  output logic [3:0]      capture_pin_out,
  output int              toggles_out
);
  logic last_out0;

  initial begin
    capture_pin_out = 4'h0;
    toggles_out     = 0;
    last_out0       = 1'b0;
  end

  // ****************************************
  // pin drive and load
  // ****************************************
  // pins follow the asked level one cycle late, as a slow external driver would
  always @(posedge clk_in) begin
    capture_pin_out <= pin_level_in;
    last_out0       <= compare_out_0_in;
    if (compare_out_0_in !== last_out0) begin
      toggles_out <= toggles_out + 1;
    end
  end
endmodule

// >>> sim/tb_tmr_top.sv
// self-checking testbench of the timer in pwm and free-running modes
`timescale 1ns/1ns
module tb_tmr_top;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        count_tick_in = 1'b1;
  logic [5:0]  avs_address_in = 6'h00;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic [3:0]  capture_in_m_in;
  logic [3:0]  pin_level = 4'h0;
  logic        compare_out_0_out;
  logic [2:0]  pwm_out_k_out;
  logic        period_match_irq_out;
  logic [2:0]  chan_match_irq_out;
  logic        wrap_irq_out;
  logic        wrap_flag_out;
  int          ext_tog;
  int          err_total = 0;
  int          n_compared = 0;
  int          seed = 32'heb88;
  int          tot[9] = '{default: 0};
  int          base[9];
  logic [31:0] q;
  logic [31:0] c1;
  logic [31:0] c2;
  int          v2;

  tmr_top uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
    .count_tick_in(count_tick_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hf),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .capture_in_m_in(capture_in_m_in), .compare_out_0_out(compare_out_0_out),
    .pwm_out_k_out(pwm_out_k_out), .period_match_irq_out(period_match_irq_out),
    .chan_match_irq_out(chan_match_irq_out), .wrap_irq_out(wrap_irq_out),
    .wrap_flag_out(wrap_flag_out));

  tmr_ext_model ext (.clk_in(clk_in), .pin_level_in(pin_level),
    .compare_out_0_in(compare_out_0_out), .capture_pin_out(capture_in_m_in),
    .toggles_out(ext_tog));

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  // ****************************************
  // running totals of outputs, differenced per window
  // ****************************************
  always @(posedge clk_in) begin
    for (int k = 0; k < 3; k++) begin
      if (pwm_out_k_out[k] === 1'b1) tot[k] <= tot[k] + 1;
      if (chan_match_irq_out[k] === 1'b1) tot[3+k] <= tot[3+k] + 1;
    end
    if (period_match_irq_out === 1'b1) tot[6] <= tot[6] + 1;
    if (wrap_irq_out === 1'b1) tot[7] <= tot[7] + 1;
    tot[8] <= ext_tog;
  end

  function automatic int dl(input int i);
    return tot[i] - base[i];
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h got %h", nm, e, g);
    end
  endtask

  // held request until the edge that samples waitrequest low, answer taken there
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_write_in     <= wr;
    avs_read_in      <= ~wr;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50) chk("bus_answer", 32'h0, 32'h1);
    q = avs_readdata_out;
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  task automatic wch(input int k, input logic [31:0] d);
    bus(1'b1, tmr_pkg::OFF_CH0 + 6'(tmr_pkg::OFF_STEP * k), d);
  endtask

  task automatic wait_pulse(input int which, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while ((which == 0 ? period_match_irq_out : wrap_irq_out) !== 1'b1 && n < lim);
    if (n >= lim) chk("pulse_wait", 32'h0, 32'h1);
  endtask

  // window of 60 cycles: a whole number of periods, so phase does not matter
  task automatic pwm_meas(input int p, input int va, input int vb, input int vc);
    int v[3];
    v = '{va, vb, vc};
    base = tot;
    repeat (60) @(posedge clk_in);
    chk("period_irq", 60 / p, dl(6));
    chk("out0_toggles", 60 / p, dl(8));
    for (int k = 0; k < 3; k++) begin
      chk("active_cycles", (v[k] < p ? v[k] : p) * 60 / p, dl(k));
      chk("chan_irq", v[k] < p ? 60 / p : 0, dl(3 + k));
    end
  endtask

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk_in);
    err_total++;
    end_of_test();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    bus(1'b0, tmr_pkg::OFF_CNT, 32'h0);
    chk("cnt_reset", 32'hffff, q);
    bus(1'b0, 6'h3c, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test reset done");
    // pwm: random option and edge settings must not matter
    bus(1'b1, tmr_pkg::OFF_OPT, 32'($random(seed)) & 32'h1e);
    bus(1'b1, tmr_pkg::OFF_EDGE, 32'($random(seed)) & 32'hff);
    pin_level <= 4'hf;
    v2 = ($random(seed) & 32'h7fff) % 11;
    wch(0, 32'd9);
    wch(2, 32'(v2));
    wch(3, 32'd10);
    wch(1, 32'd0);
    bus(1'b1, tmr_pkg::OFF_CTRL, {28'h0, tmr_pkg::TMR_MODE_PWM, 1'b1});
    repeat (30) @(posedge clk_in);
    pwm_meas(10, 0, v2, 10);
    wch(0, 32'd4);
    repeat (12) @(posedge clk_in);
    pwm_meas(10, 0, v2, 10);
    wch(1, 32'd0);
    // a period pulse may already stand from a wrap before the write; wait past it too
    wait_pulse(0, 100);
    wait_pulse(0, 100);
    repeat (8) @(posedge clk_in);
    pwm_meas(5, 0, v2, 10);
    $display("test pwm done");
    bus(1'b1, tmr_pkg::OFF_CTRL, {28'h0, tmr_pkg::TMR_MODE_PWM, 1'b0});
    repeat (3) @(posedge clk_in);
    chk("stop_outs", 4'h0, {compare_out_0_out, pwm_out_k_out});
    bus(1'b0, tmr_pkg::OFF_CNT, 32'h0);
    chk("stop_cnt", 32'hffff, q);
    // free run: ch0/ch1 compare, ch2 rising capture, ch3 falling capture
    pin_level <= 4'h0;
    bus(1'b1, tmr_pkg::OFF_OPT, 32'h18);
    bus(1'b1, tmr_pkg::OFF_EDGE, 32'h90);
    wch(0, 32'd20);
    wch(1, 32'd40);
    bus(1'b1, tmr_pkg::OFF_CTRL, {28'h0, tmr_pkg::TMR_MODE_FREE, 1'b1});
    repeat (4) @(posedge clk_in);
    chk("start_invert", 4'hf, {compare_out_0_out, pwm_out_k_out});
    base = tot;
    repeat (100) @(posedge clk_in);
    chk("match_toggle", 4'h6, {compare_out_0_out, pwm_out_k_out});
    chk("match_irq", 32'h2, dl(6) + dl(3));
    bus(1'b0, tmr_pkg::OFF_CNT, 32'h0);
    wch(1, q + 32'd60);
    base = tot;
    repeat (100) @(posedge clk_in);
    chk("late_compare", 32'h1, {31'h0, pwm_out_k_out[0]});
    chk("late_irq", 32'h1, dl(3));
    bus(1'b0, tmr_pkg::OFF_CNT, 32'h0);
    c1 = q;
    base = tot;
    pin_level <= 4'h4;
    repeat (10) @(posedge clk_in);
    bus(1'b0, tmr_pkg::OFF_CH0 + 6'h08, 32'h0);
    v2 = int'(q);
    bus(1'b0, tmr_pkg::OFF_CNT, 32'h0);
    c2 = q;
    chk("cap_inside", 32'h1, {31'h0, 32'(v2) > c1 && c2 > 32'(v2)});
    chk("cap_irq", 32'h1, dl(4));
    pin_level <= 4'hc;
    repeat (10) @(posedge clk_in);
    chk("cap_wrong_edge", 32'h0, dl(5));
    pin_level <= 4'h4;
    repeat (10) @(posedge clk_in);
    chk("cap_fall", 32'h1, dl(5));
    count_tick_in <= 1'b0;
    bus(1'b0, tmr_pkg::OFF_CNT, 32'h0);
    c1 = q;
    repeat (20) @(posedge clk_in);
    bus(1'b0, tmr_pkg::OFF_CNT, 32'h0);
    chk("no_tick_hold", c1, q);
    count_tick_in <= 1'b1;
    $display("test free compare capture done");
    base = tot;
    wait_pulse(1, 70000);
    repeat (2) @(posedge clk_in);
    chk("wrap_flag_set", 32'h1, {31'h0, wrap_flag_out});
    chk("wrap_irq", 32'h1, dl(7));
    bus(1'b0, tmr_pkg::OFF_CNT, 32'h0);
    chk("cnt_wrapped", 32'h1, {31'h0, q < 32'h40});
    repeat (300) @(posedge clk_in);
    bus(1'b0, tmr_pkg::OFF_OPT, 32'h0);
    chk("flag_sticky", 32'h19, q & 32'h1f);
    bus(1'b1, tmr_pkg::OFF_OPT, 32'h18);
    repeat (2) @(posedge clk_in);
    chk("flag_cleared", 32'h0, {31'h0, wrap_flag_out});
    $display("test overflow done");
    end_of_test();
  end
endmodule
